/* File: design/modbus_pkg.sv */
package modbus_pkg;

   // ****************************************
   // framing characters and limits
   // ****************************************
   localparam logic [7:0]  CHAR_START    = 8'h3A;
   localparam logic [7:0]  CHAR_CR       = 8'h0D;
   localparam logic [7:0]  CHAR_LF       = 8'h0A;
   localparam logic [6:0]  FRAME_MAX     = 7'h50;
   localparam logic [6:0]  RTU_MIN_LEN   = 7'h04;
   localparam logic [6:0]  ASCII_MIN_LEN = 7'h03;
   localparam logic [6:0]  RTU_CHK_LEN   = 7'h02;
   localparam logic [6:0]  ASCII_CHK_LEN = 7'h01;
   localparam logic [6:0]  HDR_LEN       = 7'h02;

   // ****************************************
   // station addresses
   // ****************************************
   localparam logic [7:0]  ADDR_BCAST    = 8'h00;
   localparam logic [7:0]  ADDR_MAX      = 8'h20;

   // ****************************************
   // function and exception codes
   // ****************************************
   localparam logic [7:0]  FN_READ       = 8'h03;
   localparam logic [7:0]  FN_WRITE_ONE  = 8'h06;
   localparam logic [7:0]  FN_LOOP       = 8'h08;
   localparam logic [7:0]  FN_WRITE_MANY = 8'h10;
   localparam logic [7:0]  EXC_BIT       = 8'h80;
   localparam logic [7:0]  EXC_NONE      = 8'h00;
   localparam logic [7:0]  EXC_FUNC      = 8'h51;
   localparam logic [7:0]  EXC_ADDR      = 8'h52;
   localparam logic [7:0]  EXC_QTY       = 8'h53;
   localparam logic [7:0]  EXC_RANGE     = 8'h54;
   localparam logic [7:0]  EXC_MODE      = 8'h55;

   // ****************************************
   // check codes
   // ****************************************
   localparam logic [15:0] CRC_PRESET    = 16'hFFFF;
   localparam logic [15:0] CRC_POLY      = 16'hA001;
   localparam logic [7:0]  SUM_PRESET    = 8'h00;

   // ****************************************
   // timing and output fifo size
   // ****************************************
   localparam int          CLK_HZ        = 20000000;
   localparam int          GAP_MS        = 10;
   localparam int          GAP_CYCLES    = (GAP_MS * CLK_HZ + 999) / 1000;
   localparam int          GAP_W         = 18;
   localparam int          FIFO_DEPTH    = 4;
   localparam int          FIFO_WIDTH    = 8;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [3:0] {
      S_RX, S_CHECK, S_CMD, S_GAP, S_START, S_ADDR, S_FUNC,
      S_BODY, S_EXC, S_CK_LO, S_CK_HI, S_CR, S_LF
   } state_t;

   typedef struct packed {
      logic [7:0]  func;
      logic [15:0] start;
      logic [15:0] value;
      logic [6:0]  nbytes;
      logic        bcast;
   } cmd_t;

   typedef struct packed {
      logic [7:0]  data;
      logic        last;
   } body_t;

endpackage

/* File: design/modbus_slave_frame_handler.sv */
`timescale 1ns/1ns

// ****************************************
// output fifo
// ****************************************
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      fill;
   logic             do_wr;
   logic             do_rd;

   assign in_ready  = (fill != (AW+1)'(DEPTH));
   assign out_valid = (fill != '0);
   assign out_data  = mem[rd_ptr];
   assign do_wr     = in_valid && in_ready;
   assign do_rd     = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill   <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         if (do_wr && !do_rd) begin
            fill <= fill + 1'b1;
         end else if (do_rd && !do_wr) begin
            fill <= fill - 1'b1;
         end
      end
   end
endmodule

// ****************************************
// frame handler
// ****************************************
module modbus_slave_frame_handler #(
   parameter int GAP_CYCLES = modbus_pkg::GAP_CYCLES
) (
   input  wire logic               clk,
   input  wire logic               resetn,
   input  wire logic               ascii_mode_pin,
   input  wire logic [7:0]         station_pin,
   input  wire logic               rx_valid,
   input  wire logic [7:0]         rx_data,
   output      logic               cmd_valid,
   output      modbus_pkg::cmd_t   cmd,
   input  wire logic [6:0]         data_idx,
   output      logic [7:0]         data_byte,
   input  wire logic               app_done,
   input  wire logic [7:0]         app_exc,
   input  wire logic               body_valid,
   input  wire modbus_pkg::body_t  body,
   output      logic               body_ready,
   output      logic               tx_valid,
   output      logic [7:0]         tx_data,
   input  wire logic               tx_ready,
   output      logic               frame_drop
);

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                            input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ modbus_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   function automatic logic [7:0] hex_char(input logic [3:0] n);
      return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction

   function automatic logic [4:0] hex_val(input logic [7:0] ch);
      logic [4:0] v;
      v = 5'h00;
      if (ch >= 8'h30 && ch <= 8'h39) begin
         v = {1'b1, ch[3:0]};
      end else if ((ch >= 8'h41 && ch <= 8'h46) ||
                   (ch >= 8'h61 && ch <= 8'h66)) begin
         v = {1'b1, ch[3:0] + 4'h9};
      end
      return v;
   endfunction

   function automatic logic fn_supported(input logic [7:0] f);
      return (f == modbus_pkg::FN_READ)      ||
             (f == modbus_pkg::FN_WRITE_ONE) ||
             (f == modbus_pkg::FN_LOOP)      ||
             (f == modbus_pkg::FN_WRITE_MANY);
   endfunction

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [8:0] pin_s1;
   logic [8:0] pin_s2;
   logic [8:0] pin_s3;
   logic [8:0] pin_val;
   logic       ascii;
   logic [7:0] station;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         pin_s1  <= '0;
         pin_s2  <= '0;
         pin_s3  <= '0;
         pin_val <= '0;
      end else begin
         pin_s1 <= {ascii_mode_pin, station_pin};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         if (pin_s2 == pin_s3) begin
            pin_val <= pin_s3;
         end
      end
   end

   assign ascii   = pin_val[8];
   assign station = pin_val[7:0];

   // ****************************************
   // shared state
   // ****************************************
   localparam int GAP_W_C = modbus_pkg::GAP_W;

   modbus_pkg::state_t state;
   logic [7:0]  frame_buf [0:79];
   logic [6:0]  cnt;
   logic [6:0]  chars;
   logic        active;
   logic        half_rx;
   logic [3:0]  nib_hi;
   logic        seen_cr;
   logic        too_long;
   logic        bad;
   logic [15:0] crc;
   logic [7:0]  sum;
   logic [7:0]  exc;
   logic        half_tx;
   logic [GAP_W_C-1:0] idle;

   logic [4:0]  rx_hex;
   logic [7:0]  rx_byte;
   logic        rx_take;
   logic        rx_store;
   logic        frame_end;
   logic        gap_done;
   logic        addr_hit;
   logic        frame_ok;
   logic        is_bcast;
   logic        hexed;
   logic        emit;
   logic [7:0]  out_byte;
   logic [7:0]  fifo_in;
   logic        fifo_ready;
   logic        push;
   logic        byte_done;
   logic        data_state;

   // ****************************************
   // receive path
   // ****************************************
   assign rx_hex   = hex_val(rx_data);
   assign rx_take  = (state == modbus_pkg::S_RX) && rx_valid;
   assign rx_byte  = ascii ? {nib_hi, rx_hex[3:0]} : rx_data;
   assign rx_store = rx_take && (ascii ? (active && !seen_cr &&
                     rx_hex[4] && half_rx) : 1'b1);
   assign gap_done = (idle == GAP_W_C'(GAP_CYCLES));
   assign frame_end = ascii ?
          (rx_take && active && seen_cr &&
           rx_data == modbus_pkg::CHAR_LF) :
          (state == modbus_pkg::S_RX && cnt != '0 && gap_done);

   always_ff @(posedge clk) begin
      if (!resetn || state != modbus_pkg::S_RX) begin
         cnt      <= '0;
         chars    <= '0;
         active   <= 1'b0;
         half_rx  <= 1'b0;
         nib_hi   <= '0;
         seen_cr  <= 1'b0;
         too_long <= 1'b0;
         bad      <= 1'b0;
      end else if (rx_take && ascii) begin
         if (rx_data == modbus_pkg::CHAR_START) begin
            active   <= 1'b1;
            cnt      <= '0;
            chars    <= 7'h01;
            half_rx  <= 1'b0;
            seen_cr  <= 1'b0;
            too_long <= 1'b0;
            bad      <= 1'b0;
         end else if (active) begin
            if (chars == modbus_pkg::FRAME_MAX) begin
               too_long <= 1'b1;
            end else begin
               chars <= chars + 1'b1;
            end
            if (rx_data == modbus_pkg::CHAR_CR) begin
               seen_cr <= 1'b1;
            end else if (rx_hex[4] && !seen_cr) begin
               half_rx <= !half_rx;
               nib_hi  <= rx_hex[3:0];
               if (half_rx && cnt != modbus_pkg::FRAME_MAX) begin
                  cnt <= cnt + 1'b1;
               end
            end else if (rx_data != modbus_pkg::CHAR_LF) begin
               bad <= 1'b1;
            end
         end
      end else if (rx_take) begin
         if (cnt == modbus_pkg::FRAME_MAX) begin
            too_long <= 1'b1;
         end else begin
            cnt <= cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rx_store && cnt != modbus_pkg::FRAME_MAX) begin
         frame_buf[cnt] <= rx_byte;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         idle <= '0;
      end else if (rx_valid) begin
         idle <= '0;
      end else if (!gap_done) begin
         idle <= idle + 1'b1;
      end
   end

   // ****************************************
   // check accumulators
   // ****************************************
   assign data_state = (state == modbus_pkg::S_ADDR) ||
                       (state == modbus_pkg::S_FUNC) ||
                       (state == modbus_pkg::S_BODY) ||
                       (state == modbus_pkg::S_EXC);

   always_ff @(posedge clk) begin
      if (!resetn || state == modbus_pkg::S_GAP) begin
         crc <= modbus_pkg::CRC_PRESET;
         sum <= modbus_pkg::SUM_PRESET;
      end else if (rx_store) begin
         crc <= crc_byte((cnt == '0) ? modbus_pkg::CRC_PRESET : crc,
                         rx_byte);
         sum <= ((cnt == '0) ? modbus_pkg::SUM_PRESET : sum) + rx_byte;
      end else if (byte_done && data_state) begin
         crc <= crc_byte(crc, out_byte);
         sum <= sum + out_byte;
      end
   end

   // ****************************************
   // frame acceptance
   // ****************************************
   assign is_bcast = (frame_buf[0] == modbus_pkg::ADDR_BCAST);
   assign addr_hit = is_bcast || (frame_buf[0] == station &&
                     station != modbus_pkg::ADDR_BCAST &&
                     station <= modbus_pkg::ADDR_MAX);
   assign frame_ok = !too_long && !bad && addr_hit &&
          (ascii ? (sum == modbus_pkg::SUM_PRESET &&
                    cnt >= modbus_pkg::ASCII_MIN_LEN) :
                   (crc == 16'h0000 &&
                    cnt >= modbus_pkg::RTU_MIN_LEN));

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cmd <= '0;
      end else if (state == modbus_pkg::S_CHECK) begin
         cmd.func   <= frame_buf[1];
         cmd.start  <= {frame_buf[2], frame_buf[3]};
         cmd.value  <= {frame_buf[4], frame_buf[5]};
         cmd.bcast  <= is_bcast;
         cmd.nbytes <= cnt - modbus_pkg::HDR_LEN - (ascii ?
                       modbus_pkg::ASCII_CHK_LEN : modbus_pkg::RTU_CHK_LEN);
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         data_byte <= '0;
      end else if (data_idx < modbus_pkg::FRAME_MAX) begin
         data_byte <= frame_buf[data_idx];
      end else begin
         data_byte <= '0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         frame_drop <= 1'b0;
      end else begin
         frame_drop <= (state == modbus_pkg::S_CHECK) && !frame_ok;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         exc <= modbus_pkg::EXC_NONE;
      end else if (state == modbus_pkg::S_CHECK) begin
         exc <= fn_supported(frame_buf[1]) ? modbus_pkg::EXC_NONE :
                modbus_pkg::EXC_FUNC;
      end else if (state == modbus_pkg::S_CMD && app_done) begin
         exc <= app_exc;
      end
   end

   assign cmd_valid = (state == modbus_pkg::S_CMD);

   // ****************************************
   // sequencer
   // ****************************************
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state <= modbus_pkg::S_RX;
      end else begin
         case (state)
            modbus_pkg::S_RX: begin
               if (frame_end) begin
                  state <= modbus_pkg::S_CHECK;
               end
            end
            modbus_pkg::S_CHECK: begin
               if (!frame_ok) begin
                  state <= modbus_pkg::S_RX;
               end else if (fn_supported(frame_buf[1])) begin
                  state <= modbus_pkg::S_CMD;
               end else if (is_bcast) begin
                  state <= modbus_pkg::S_RX;
               end else begin
                  state <= modbus_pkg::S_GAP;
               end
            end
            modbus_pkg::S_CMD: begin
               if (app_done) begin
                  state <= cmd.bcast ? modbus_pkg::S_RX :
                           modbus_pkg::S_GAP;
               end
            end
            modbus_pkg::S_GAP: begin
               if (gap_done) begin
                  state <= ascii ? modbus_pkg::S_START :
                           modbus_pkg::S_ADDR;
               end
            end
            modbus_pkg::S_START: begin
               if (push) begin
                  state <= modbus_pkg::S_ADDR;
               end
            end
            modbus_pkg::S_ADDR: begin
               if (byte_done) begin
                  state <= modbus_pkg::S_FUNC;
               end
            end
            modbus_pkg::S_FUNC: begin
               if (byte_done) begin
                  state <= (exc != modbus_pkg::EXC_NONE) ?
                           modbus_pkg::S_EXC : modbus_pkg::S_BODY;
               end
            end
            modbus_pkg::S_BODY: begin
               if (byte_done && body.last) begin
                  state <= modbus_pkg::S_CK_LO;
               end
            end
            modbus_pkg::S_EXC: begin
               if (byte_done) begin
                  state <= modbus_pkg::S_CK_LO;
               end
            end
            modbus_pkg::S_CK_LO: begin
               if (byte_done) begin
                  state <= ascii ? modbus_pkg::S_CR :
                           modbus_pkg::S_CK_HI;
               end
            end
            modbus_pkg::S_CR: begin
               if (push) begin
                  state <= modbus_pkg::S_LF;
               end
            end
            modbus_pkg::S_CK_HI,
            modbus_pkg::S_LF: begin
               if (push) begin
                  state <= modbus_pkg::S_RX;
               end
            end
            default: begin
               state <= modbus_pkg::S_RX;
            end
         endcase
      end
   end

   // ****************************************
   // transmit path
   // ****************************************
   always_comb begin
      out_byte = 8'h00;
      emit     = 1'b1;
      hexed    = ascii;
      case (state)
         modbus_pkg::S_START: begin
            out_byte = modbus_pkg::CHAR_START;
            hexed    = 1'b0;
         end
         modbus_pkg::S_ADDR:  out_byte = station;
         modbus_pkg::S_FUNC: begin
            out_byte = (exc != modbus_pkg::EXC_NONE) ?
                       (cmd.func | modbus_pkg::EXC_BIT) :
                       cmd.func;
         end
         modbus_pkg::S_BODY: begin
            out_byte = body.data;
            emit     = body_valid;
         end
         modbus_pkg::S_EXC:   out_byte = exc;
         modbus_pkg::S_CK_LO: begin
            out_byte = ascii ? (~sum + 8'h01) : crc[7:0];
         end
         modbus_pkg::S_CK_HI: out_byte = crc[15:8];
         modbus_pkg::S_CR: begin
            out_byte = modbus_pkg::CHAR_CR;
            hexed    = 1'b0;
         end
         modbus_pkg::S_LF: begin
            out_byte = modbus_pkg::CHAR_LF;
            hexed    = 1'b0;
         end
         default: begin
            emit  = 1'b0;
            hexed = 1'b0;
         end
      endcase
   end

   assign fifo_in    = hexed ? hex_char(half_tx ? out_byte[3:0] :
                                         out_byte[7:4]) : out_byte;
   assign push       = emit && fifo_ready;
   assign byte_done  = push && (!hexed || half_tx);
   assign body_ready = (state == modbus_pkg::S_BODY) && byte_done;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         half_tx <= 1'b0;
      end else if (push && hexed) begin
         half_tx <= !half_tx;
      end
   end

   byte_fifo #(
      .WIDTH (modbus_pkg::FIFO_WIDTH),
      .DEPTH (modbus_pkg::FIFO_DEPTH)
   ) u_tx_fifo (
      .clk       (clk),
      .resetn    (resetn),
      .in_valid  (emit),
      .in_ready  (fifo_ready),
      .in_data   (fifo_in),
      .out_valid (tx_valid),
      .out_ready (tx_ready),
      .out_data  (tx_data)
   );

endmodule

/* File: bench/modbus_frame_properties.sv */
`timescale 1ns/1ns
module modbus_frame_properties #(
   parameter int GAP_CYCLES = 50
) (
   input wire logic             clk,
   input wire logic             resetn,
   input wire logic             rx_valid,
   input wire logic             cmd_valid,
   input wire modbus_pkg::cmd_t cmd,
   input wire logic [6:0]       data_idx,
   input wire logic [7:0]       data_byte,
   input wire logic             app_done,
   input wire logic             body_valid,
   input wire logic             body_ready,
   input wire logic             tx_valid,
   input wire logic [7:0]       tx_data,
   input wire logic             tx_ready,
   input wire logic             frame_drop
);
   int idle;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // idle cycles since the last received byte
   always_ff @(posedge clk) begin
      if (!resetn || rx_valid) begin
         idle <= 0;
      end else if (idle < GAP_CYCLES) begin
         idle <= idle + 1;
      end
   end
   sequence s_wait; cmd_valid && !app_done; endsequence
   sequence s_done; cmd_valid && app_done; endsequence
   property p_cmd_hold; s_wait |=> cmd_valid && $stable(cmd); endproperty
   a_cmd_hold: assert property (p_cmd_hold)
      else $error("command not held");
   property p_cmd_fall; s_done |=> !cmd_valid; endproperty
   a_cmd_fall: assert property (p_cmd_fall)
      else $error("command not released");
   property p_bcast; s_done ##0 cmd.bcast |=> !tx_valid [*8]; endproperty
   a_bcast: assert property (p_bcast)
      else $error("broadcast answered");
   property p_drop; frame_drop |-> !cmd_valid; endproperty
   a_drop: assert property (p_drop)
      else $error("dropped frame issued");
   property p_gap; $rose(tx_valid) |-> idle >= GAP_CYCLES; endproperty
   a_gap: assert property (p_gap)
      else $error("reply inside idle gap");
   property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
   endproperty
   a_tx_hold: assert property (p_tx_hold)
      else $error("tx byte lost");
   property p_body; body_ready |-> body_valid && !cmd_valid; endproperty
   a_body: assert property (p_body)
      else $error("body taken wrongly");
   property p_idx; data_idx >= 7'h50 |=> data_byte == 8'h00; endproperty
   a_idx: assert property (p_idx)
      else $error("byte beyond frame limit");
endmodule
bind modbus_slave_frame_handler modbus_frame_properties #(
   .GAP_CYCLES(GAP_CYCLES)
) i_props (.clk(clk), .resetn(resetn), .rx_valid(rx_valid),
   .cmd_valid(cmd_valid), .cmd(cmd), .data_idx(data_idx),
   .data_byte(data_byte), .app_done(app_done), .body_valid(body_valid),
   .body_ready(body_ready), .tx_valid(tx_valid), .tx_data(tx_data),
   .tx_ready(tx_ready), .frame_drop(frame_drop));

/* File: bench/modbus_master_model.sv */
`timescale 1ns/1ns
module modbus_master_model (
   input  wire logic       clk,
   output      logic       rx_valid,
   output      logic [7:0] rx_data,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output      logic       tx_ready
);
   logic [7:0] rxq[$];
   logic       stall = 0;
   logic [2:0] slow = 0;
   initial begin
      rx_valid = 0;
      rx_data = 8'h5A;
      tx_ready = 1;
   end
   // one byte a cycle, then the line shows a changed value
   task automatic send(input logic [7:0] q[$]);
      foreach (q[i]) begin
         @(negedge clk);
         rx_valid = 1;
         rx_data = q[i];
      end
      @(negedge clk);
      rx_valid = 0;
      rx_data = ~rx_data;
   endtask
   always @(negedge clk) begin
      slow <= slow + 3'h1;
      tx_ready <= !stall || slow == 3'h0;
   end
   always @(posedge clk) if (tx_valid && tx_ready) rxq.push_back(tx_data);
endmodule

/* File: bench/modbus_slave_frame_handler_tb.sv */
`timescale 1ns/1ns
module modbus_slave_frame_handler_tb;
   localparam int GAP = 50;
   logic              clk = 0, resetn = 0, rx_valid, cmd_valid, app_done = 0;
   logic [7:0]        rx_data, data_byte, tx_data, app_exc = 0;
   logic [6:0]        data_idx = 0;
   logic              body_valid = 0, body_ready, tx_valid, tx_ready;
   logic              frame_drop, ascii_pin = 0;
   modbus_pkg::cmd_t  cmd;
   modbus_pkg::body_t body = '0;
   int                err_total = 0, comparisons = 0;
   always #25 clk = ~clk;
   modbus_slave_frame_handler #(.GAP_CYCLES(GAP))
      i_modbus_slave_frame_handler (
      .clk(clk), .resetn(resetn), .ascii_mode_pin(ascii_pin),
      .station_pin(8'h01), .rx_valid(rx_valid), .rx_data(rx_data),
      .cmd_valid(cmd_valid), .cmd(cmd), .data_idx(data_idx),
      .data_byte(data_byte), .app_done(app_done), .app_exc(app_exc),
      .body_valid(body_valid), .body(body), .body_ready(body_ready),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
      .frame_drop(frame_drop));
   modbus_master_model i_modbus_master_model (.clk(clk), .rx_valid(rx_valid),
      .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready));
   task summarize;
      $display("checks %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic timeout;
      err_total++;
      summarize();
   endtask
   function automatic logic [15:0] crc16(logic [7:0] q[$]);
      logic [15:0] c = 16'hFFFF;
      foreach (q[i]) begin
         c[7:0] ^= q[i];
         repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      end
      return c;
   endfunction
   task automatic send_req(logic [7:0] q[$], logic [7:0] flip);
      logic [15:0] c = crc16(q);
      q.push_back(c[7:0] ^ flip);
      q.push_back(c[15:8]);
      i_modbus_master_model.rxq.delete();
      i_modbus_master_model.send(q);
   endtask
   task automatic wait_ev;
      int n = 0;
      while (cmd_valid !== 1'b1 && frame_drop !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      if (n >= 400) timeout();
   endtask
   task automatic wait_rx(int len);
      int n = 0;
      while (i_modbus_master_model.rxq.size() < len && n < 3000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 3000) timeout();
   endtask
   task automatic expect_reply(logic [7:0] q[$]);
      logic [15:0] c = crc16(q);
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      wait_rx(q.size());
      foreach (q[i]) chk("reply", q[i], i_modbus_master_model.rxq[i]);
   endtask
   task automatic complete(logic [7:0] exc);
      app_done = 1;
      app_exc = exc;
      @(negedge clk);
      app_done = 0;
      chk("cmd_valid after done", 0, cmd_valid);
   endtask
   task automatic expect_drop(logic [7:0] q[$], logic [7:0] flip);
      send_req(q, flip);
      wait_ev();
      chk("frame_drop", 1, frame_drop);
      chk("cmd_valid", 0, cmd_valid);
   endtask
   task automatic t_read;
      int n;
      i_modbus_master_model.stall = 1;
      send_req('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 8'h00);
      wait_ev();
      chk("cmd_valid", 1, cmd_valid);
      chk("func", 8'h03, cmd.func);
      chk("value", 16'h0001, cmd.value);
      data_idx = 7'h01;
      @(negedge clk);
      chk("data_byte", 8'h03, data_byte);
      complete(8'h00);
      for (int i = 0; i < 2; i++) begin
         body_valid = 1;
         body.data = 8'h12 + 8'(i * 34);
         body.last = (i == 1);
         for (n = 0; body_ready !== 1'b1 && n < 3000; n++) @(negedge clk);
         if (n >= 3000) timeout();
         @(negedge clk);
      end
      body_valid = 0;
      expect_reply('{8'h01, 8'h03, 8'h12, 8'h34});
      i_modbus_master_model.stall = 0;
      $display("read test done");
   endtask
   task automatic t_exc;
      send_req('{8'h01, 8'h06, 8'h00, 8'h01, 8'h00, 8'h05}, 8'h00);
      wait_ev();
      chk("start", 16'h0001, cmd.start);
      chk("nbytes", 4, cmd.nbytes);
      complete(8'h52);
      expect_reply('{8'h01, 8'h86, 8'h52});
      send_req('{8'h01, 8'h05, 8'h00, 8'h01, 8'h00, 8'h05}, 8'h00);
      expect_reply('{8'h01, 8'h85, 8'h51});
      $display("exception test done");
   endtask
   task automatic t_bad;
      logic [7:0] q[$];
      for (int i = 0; i < 79; i++) q.push_back(8'h01);
      expect_drop('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 8'h01);
      expect_drop('{8'h02, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 8'h00);
      expect_drop(q, 8'h00);
      $display("drop test done");
   endtask
   task automatic t_bcast;
      send_req('{8'h00, 8'h06, 8'h00, 8'h01, 8'h00, 8'h07}, 8'h00);
      wait_ev();
      chk("bcast", 1, cmd.bcast);
      data_idx = 7'h50;
      @(negedge clk);
      chk("data_byte", 8'h00, data_byte);
      complete(8'h00);
      repeat (3 * GAP) @(negedge clk);
      chk("reply count", 0, 16'(i_modbus_master_model.rxq.size()));
      $display("broadcast test done");
   endtask
   task automatic t_ascii;
      string s = ":010600010007F1\r\n", r = ":01865425\r\n";
      logic [7:0] q[$];
      ascii_pin = 1;
      repeat (8) @(negedge clk);
      foreach (s[i]) q.push_back(s[i]);
      i_modbus_master_model.rxq.delete();
      i_modbus_master_model.send(q);
      wait_ev();
      chk("start", 16'h0001, cmd.start);
      complete(8'h54);
      wait_rx(r.len());
      foreach (r[i]) chk("char", r[i], i_modbus_master_model.rxq[i]);
      $display("ascii test done");
   endtask
   initial begin
      repeat (6) @(negedge clk);
      resetn = 1;
      repeat (10) @(negedge clk);
      t_read();
      t_exc();
      t_bad();
      t_bcast();
      t_ascii();
      summarize();
   end
endmodule
